/* File: rtl/pchd_pkg.sv */
// Constants, register map and carrier types of the configuration default bank
// Behaviour
// [RULE_01] Release bit resets to not-autoinit; hold host otherwise
// [RULE_02] Autoinit select sampled during reset picks boot init
// [RULE_03] Boot software writes release bit once done
// [RULE_04] Bit 0: zero forbids, one allows host
// [RULE_05] Window 0 size default resets to ffc0000
// [RULE_06] Window 1 size default resets to ff80000
// [RULE_07] Window 2 size default resets to ffffff
// [RULE_08] Window 3 to 5 size defaults reset zero
// [RULE_09] Size default bits 31-28 read zero
// [RULE_10] Window 0 attribute bit 0 resets one
// [RULE_11] Interface reset copies defaults into live registers
// [RULE_12] Software may overwrite defaults before the copy
// [RULE_13] Writes to reserved bits are dropped
package pchd_pkg;

   // ----------------------------------------
   // Bus geometry
   // ----------------------------------------
   localparam int ADR_W    = 8;
   localparam int DAT_W    = 32;
   localparam int SEL_W    = 4;
   localparam int NUM_WIN  = 6;
   localparam int MASK_W   = 28;

   // ----------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [ADR_W-1:0] OFS_RELEASE   = 8'h00;
   localparam logic [ADR_W-1:0] OFS_WIN_SIZE0 = 8'h04;
   localparam logic [ADR_W-1:0] OFS_WIN_STEP  = 8'h04;
   localparam logic [ADR_W-1:0] OFS_WIN0_ATTR = 8'h1c;

   // ----------------------------------------
   // Fields and reset values
   // ----------------------------------------
   localparam int RELEASE_BIT  = 0;
   localparam int PREFETCH_BIT = 0;
   localparam logic [NUM_WIN-1:0][MASK_W-1:0] WIN_SIZE_RST = {
      28'h0000000, 28'h0000000, 28'h0000000,
      28'h0ffffff, 28'hff80000, 28'hffc0000};
   localparam logic ATTR_RST = 1'b1;

   // ----------------------------------------
   // Carrier types
   // ----------------------------------------
   typedef struct packed {
      logic             cyc;
      logic             stb;
      logic             we;
      logic [ADR_W-1:0] adr;
      logic [SEL_W-1:0] sel;
      logic [DAT_W-1:0] dat;
   } pchd_wb_req_t;

   typedef struct packed {
      logic [NUM_WIN-1:0][MASK_W-1:0] mask;
      logic                           prefetch0;
   } pchd_live_t;

   function automatic logic [ADR_W-1:0] win_ofs(input int idx);
      win_ofs = OFS_WIN_SIZE0 + OFS_WIN_STEP * ADR_W'(idx);
   endfunction

endpackage

/* File: rtl/pchd_field_reg.sv */
// Byte-lane writable field register; bits above the field are dropped
`timescale 1ns/1ps
module pchd_field_reg #(
   parameter int         W   = 28,
   parameter logic [W-1:0] RST = '0
) (
   input  wire logic                          clk_i,
   input  wire logic                          rst_i,
   input  wire logic                          wr_i,
   input  wire logic [pchd_pkg::SEL_W-1:0]    sel_i,
   input  wire logic [pchd_pkg::DAT_W-1:0]    dat_i,
   output logic      [W-1:0]                  q_o
);

   typedef struct packed {
      logic [W-1:0] val;
   } pchd_fr_state_t;

   pchd_fr_state_t st_ff;
   pchd_fr_state_t nxt_st;

   always_comb begin
      logic [pchd_pkg::DAT_W-1:0] merged;
      merged = pchd_pkg::DAT_W'(st_ff.val);
      nxt_st = st_ff;
      for (int b = 0; b < pchd_pkg::SEL_W; b++) begin
         if (sel_i[b]) begin
            merged[8*b +: 8] = dat_i[8*b +: 8];
         end
      end
      if (wr_i) begin
         // Only the field width is kept  (see [RULE_13])
         nxt_st.val = merged[W-1:0]; // see [RULE_12]
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff.val <= RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign q_o = st_ff.val;

endmodule

/* File: rtl/pchd_live_copy.sv */
// Live configuration registers loaded from the defaults on interface reset
`timescale 1ns/1ps
module pchd_live_copy (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 pci_rst_i,
   input  wire pchd_pkg::pchd_live_t dflt_i,
   output pchd_pkg::pchd_live_t      live_o
);

   pchd_pkg::pchd_live_t st_ff;
   pchd_pkg::pchd_live_t nxt_st;

   always_comb begin
      nxt_st = st_ff;
      // Held for the whole interface reset, so last value written wins
      if (pci_rst_i) begin
         nxt_st = dflt_i; // see [RULE_11]
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff.mask      <= pchd_pkg::WIN_SIZE_RST;
         st_ff.prefetch0 <= pchd_pkg::ATTR_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign live_o = st_ff;

endmodule

/* File: rtl/pchd_regbank.sv */
// Configuration default bank with host hold-off, on a classic Wishbone slave
//
// The placing of the registers and register access over Wishbone were decided locally.
`timescale 1ns/1ps
module pchd_regbank (
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   input  wire pchd_pkg::pchd_wb_req_t     wb_i,
   output logic [pchd_pkg::DAT_W-1:0]      wb_dat_o,
   output logic                            wb_ack_o,
   input  wire logic                       autoinit_select_i,
   input  wire logic                       pci_rst_i,
   input  wire logic                       host_req_i,
   output logic                            host_grant_o,
   output logic                            host_hold_o,
   output pchd_pkg::pchd_live_t            live_o
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic                       release_bit;
      logic                       hold;
      logic                       grant;
      logic                       ack;
      logic [pchd_pkg::DAT_W-1:0] rdat;
   } pchd_state_t;

   pchd_state_t st_ff;
   pchd_state_t nxt_st;

   logic                                           req_new;
   logic                                           wr_cmt;
   logic [pchd_pkg::NUM_WIN-1:0]                   win_wr;
   logic [pchd_pkg::NUM_WIN-1:0][pchd_pkg::MASK_W-1:0] win_size;
   logic                                           attr_wr;
   logic                                           attr_q;
   pchd_pkg::pchd_live_t                           dflt;

   // A request is served once; ack drops the cycle after it rose
   assign req_new = wb_i.cyc && wb_i.stb && !st_ff.ack;
   assign wr_cmt  = req_new && wb_i.we;

   // ----------------------------------------
   // Default registers
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < pchd_pkg::NUM_WIN; gi++) begin : g_win
         assign win_wr[gi] = wr_cmt && (wb_i.adr == pchd_pkg::win_ofs(gi));
         pchd_field_reg #(
            .W   (pchd_pkg::MASK_W),
            .RST (pchd_pkg::WIN_SIZE_RST[gi])
         ) u_size (
            .clk_i (clk_i),
            .rst_i (rst_i),
            .wr_i  (win_wr[gi]),
            .sel_i (wb_i.sel),
            .dat_i (wb_i.dat),
            .q_o   (win_size[gi])
         ); // see [RULE_05] [RULE_06] [RULE_07] [RULE_08]
      end
   endgenerate

   assign attr_wr = wr_cmt && (wb_i.adr == pchd_pkg::OFS_WIN0_ATTR);

   pchd_field_reg #(
      .W   (1),
      .RST (pchd_pkg::ATTR_RST)
   ) u_attr (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .wr_i  (attr_wr),
      .sel_i (wb_i.sel),
      .dat_i (wb_i.dat),
      .q_o   (attr_q)
   ); // see [RULE_10]

   assign dflt.mask      = win_size;
   assign dflt.prefetch0 = attr_q;

   pchd_live_copy u_live (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .pci_rst_i (pci_rst_i),
      .dflt_i    (dflt),
      .live_o    (live_o)
   );

   // ----------------------------------------
   // Bus slave, release bit and host gate
   // ----------------------------------------
   always_comb begin
      nxt_st       = st_ff;
      nxt_st.ack   = req_new;
      nxt_st.rdat  = '0;
      if (req_new && !wb_i.we) begin
         // Unmapped or misaligned addresses read as zero
         if (wb_i.adr == pchd_pkg::OFS_RELEASE) begin
            nxt_st.rdat[pchd_pkg::RELEASE_BIT] = st_ff.release_bit;
         end else if (wb_i.adr == pchd_pkg::OFS_WIN0_ATTR) begin
            nxt_st.rdat[pchd_pkg::PREFETCH_BIT] = attr_q; // see [RULE_10]
         end else begin
            for (int i = 0; i < pchd_pkg::NUM_WIN; i++) begin
               if (wb_i.adr == pchd_pkg::win_ofs(i)) begin
                  nxt_st.rdat = pchd_pkg::DAT_W'(win_size[i]); // see [RULE_09]
               end
            end
         end
      end
      if (wr_cmt && (wb_i.adr == pchd_pkg::OFS_RELEASE) && wb_i.sel[0]) begin
         // Software may also clear it again to re-close the gate
         nxt_st.release_bit = wb_i.dat[pchd_pkg::RELEASE_BIT]; // see [RULE_03] [RULE_13]
      end
      nxt_st.hold  = !nxt_st.release_bit; // see [RULE_04]
      nxt_st.grant = host_req_i && st_ff.release_bit; // see [RULE_01] [RULE_04]
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         // Strap is watched for the whole reset  (see [RULE_02])
         st_ff.release_bit <= !autoinit_select_i; // see [RULE_01]
         st_ff.hold        <= autoinit_select_i;
         st_ff.grant       <= 1'b0;
         st_ff.ack         <= 1'b0;
         st_ff.rdat        <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign wb_dat_o     = st_ff.rdat;
   assign wb_ack_o     = st_ff.ack;
   assign host_grant_o = st_ff.grant;
   assign host_hold_o  = st_ff.hold;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_release_strap;
      @(posedge clk_i) rst_i |=> (st_ff.release_bit == !$past(autoinit_select_i));
   endproperty
   a_release_strap: assert property (p_release_strap) // see [RULE_01] [RULE_02]
      else $error("release bit reset value ignores autoinit select");

   property p_grant_gated;
      @(posedge clk_i) disable iff (rst_i)
         host_grant_o |-> ($past(st_ff.release_bit) && $past(host_req_i));
   endproperty
   a_grant_gated: assert property (p_grant_gated) // see [RULE_01]
      else $error("host granted while release bit was zero");

   property p_hold_blocks;
      @(posedge clk_i) disable iff (rst_i)
         host_hold_o |-> (!host_grant_o || !st_ff.release_bit) ##1 !host_grant_o;
   endproperty
   a_hold_blocks: assert property (p_hold_blocks) // see [RULE_04]
      else $error("host granted while hold-off shown");

   property p_release_write;
      @(posedge clk_i) disable iff (rst_i)
         (wr_cmt && wb_i.adr == pchd_pkg::OFS_RELEASE && wb_i.sel[0])
            |=> wb_ack_o && (st_ff.release_bit == $past(wb_i.dat[0])) ##1 !wb_ack_o;
   endproperty
   a_release_write: assert property (p_release_write) // see [RULE_03] [RULE_04]
      else $error("release bit write not taken");

   property p_win_reset;
      @(posedge clk_i) rst_i |=> (win_size == pchd_pkg::WIN_SIZE_RST) && attr_q;
   endproperty
   a_win_reset: assert property (p_win_reset) // see [RULE_05] [RULE_06] [RULE_07]
      else $error("default registers wrong after reset");

   property p_win_write;
      @(posedge clk_i) disable iff (rst_i)
         (wr_cmt && wb_i.adr == pchd_pkg::OFS_WIN_SIZE0 && wb_i.sel == 4'hf)
            |=> (win_size[0] == $past(wb_i.dat[pchd_pkg::MASK_W-1:0]));
   endproperty
   a_win_write: assert property (p_win_write) // see [RULE_12]
      else $error("window size default write lost");

   property p_win_rsvd;
      @(posedge clk_i) disable iff (rst_i)
         (req_new && !wb_i.we && wb_i.adr >= pchd_pkg::OFS_WIN_SIZE0
          && wb_i.adr < pchd_pkg::OFS_WIN0_ATTR) |=> wb_ack_o && (wb_dat_o[31:28] == 4'h0);
   endproperty
   a_win_rsvd: assert property (p_win_rsvd) // see [RULE_09] [RULE_13]
      else $error("reserved size bits not zero");

   property p_one_bit_rsvd;
      @(posedge clk_i) disable iff (rst_i)
         (req_new && !wb_i.we && (wb_i.adr == pchd_pkg::OFS_RELEASE
          || wb_i.adr == pchd_pkg::OFS_WIN0_ATTR)) |=> (wb_dat_o[31:1] == 31'h0);
   endproperty
   a_one_bit_rsvd: assert property (p_one_bit_rsvd) // see [RULE_10] [RULE_13]
      else $error("reserved bits above bit 0 not zero");

   property p_live_copy;
      @(posedge clk_i) disable iff (rst_i)
         pci_rst_i |=> (live_o.mask == $past(win_size)) && (live_o.prefetch0 == $past(attr_q));
   endproperty
   a_live_copy: assert property (p_live_copy) // see [RULE_11]
      else $error("live registers not loaded on interface reset");

   property p_live_hold;
      @(posedge clk_i) disable iff (rst_i)
         (!rst_i && !pci_rst_i) |=> $stable(live_o);
   endproperty
   a_live_hold: assert property (p_live_hold) // see [RULE_11]
      else $error("live registers changed outside interface reset");

   // ----------------------------------------
   // Bus and gate cross-checks
   // ----------------------------------------
   // Attempts that start on a reset edge stay vacuous:
   // the release edge would otherwise see pre-reset values
   property p_ack_pulse;
      @(posedge clk_i) disable iff (rst_i)
         wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) // see [RULE_12]
      else $error("ack stood longer than one cycle");

   property p_ack_answer;
      @(posedge clk_i) disable iff (rst_i)
         (!rst_i && req_new) |=> wb_ack_o;
   endproperty
   a_ack_answer: assert property (p_ack_answer) // see [RULE_12]
      else $error("request left without ack");

   property p_dat_idle;
      @(posedge clk_i) disable iff (rst_i)
         !wb_ack_o |-> (wb_dat_o == '0);
   endproperty
   a_dat_idle: assert property (p_dat_idle) // see [RULE_09]
      else $error("read data shown outside the ack cycle");

   property p_hold_mirror;
      @(posedge clk_i) disable iff (rst_i)
         host_hold_o == !st_ff.release_bit;
   endproperty
   a_hold_mirror: assert property (p_hold_mirror) // see [RULE_04]
      else $error("hold-off does not mirror the release bit");

   property p_hold_reset;
      @(posedge clk_i) rst_i |=> (host_hold_o == $past(autoinit_select_i))
         && !host_grant_o && !wb_ack_o;
   endproperty
   a_hold_reset: assert property (p_hold_reset) // see [RULE_01] [RULE_02]
      else $error("hold-off or grant wrong after reset");

   property p_grant_follow;
      @(posedge clk_i) disable iff (rst_i)
         (!rst_i && host_req_i && st_ff.release_bit) |=> host_grant_o;
   endproperty
   a_grant_follow: assert property (p_grant_follow) // see [RULE_04]
      else $error("host refused while release bit was one");

   property p_attr_write;
      @(posedge clk_i) disable iff (rst_i)
         (wr_cmt && wb_i.adr == pchd_pkg::OFS_WIN0_ATTR && wb_i.sel[0])
            |=> (attr_q == $past(wb_i.dat[pchd_pkg::PREFETCH_BIT]));
   endproperty
   a_attr_write: assert property (p_attr_write) // see [RULE_10] [RULE_12]
      else $error("attribute default write lost");

   property p_size_read;
      @(posedge clk_i) disable iff (rst_i)
         (req_new && !wb_i.we && wb_i.adr == pchd_pkg::OFS_WIN_SIZE0)
            |=> (wb_dat_o == pchd_pkg::DAT_W'($past(win_size[0])));
   endproperty
   a_size_read: assert property (p_size_read) // see [RULE_05] [RULE_09]
      else $error("window 0 size default read back wrong");

   property p_unmapped_read;
      @(posedge clk_i) disable iff (rst_i)
         (req_new && !wb_i.we && wb_i.adr > pchd_pkg::OFS_WIN0_ATTR)
            |=> wb_ack_o && (wb_dat_o == '0);
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) // see [RULE_13]
      else $error("unmapped read not zero");

   property p_unmapped_write;
      @(posedge clk_i) disable iff (rst_i)
         (wr_cmt && wb_i.adr > pchd_pkg::OFS_WIN0_ATTR)
            |=> $stable(win_size) && $stable(attr_q) && $stable(st_ff.release_bit);
   endproperty
   a_unmapped_write: assert property (p_unmapped_write) // see [RULE_13]
      else $error("unmapped write changed a register");

   property p_release_quiet;
      @(posedge clk_i) disable iff (rst_i)
         (!rst_i && !(wr_cmt && wb_i.adr == pchd_pkg::OFS_RELEASE && wb_i.sel[0]))
            |=> $stable(st_ff.release_bit);
   endproperty
   a_release_quiet: assert property (p_release_quiet) // see [RULE_03] [RULE_13]
      else $error("release bit changed without a write");

   property p_defaults_quiet;
      @(posedge clk_i) disable iff (rst_i)
         (!rst_i && !wr_cmt) |=> $stable(win_size) && $stable(attr_q);
   endproperty
   a_defaults_quiet: assert property (p_defaults_quiet) // see [RULE_12]
      else $error("default register changed without a write");

endmodule

/* File: verification/pchd_host_model.sv */
// Host-side stand-in that asks for access and counts grants
`timescale 1ns/1ps
module pchd_host_model (
   input  wire logic clk_i,
   input  wire logic want_i,
   input  wire logic grant_i,
   output logic      req_o,
   output int        grants_o
);
   // ----------------------------------------
   // Request level and grant tally
   // ----------------------------------------
   logic req_ff  = 1'b0;
   int   n_grant = 0;
   // Counting grants shows any leak through a closed gate
   always @(posedge clk_i) begin
      req_ff <= want_i;
      if (grant_i === 1'b1) begin
         n_grant <= n_grant + 1;
      end
   end
   assign req_o    = req_ff;
   assign grants_o = n_grant;
endmodule

/* File: verification/tb_pci_config_hook_defaults.sv */
// Self-checking bench for the configuration default bank
`timescale 1ns/1ps
`define CHK(nm, e, a) begin tests_run++; if ((a) !== (e)) begin n_errors++; \
   $display("BAD %s exp %h got %h", nm, e, a); end end
module tb_pci_config_hook_defaults;
   // ----------------------------------------
   // Signals and instances
   // ----------------------------------------
   logic                   clk_i      = 1'b0;
   logic                   rst_i      = 1'b1;
   pchd_pkg::pchd_wb_req_t wb         = '0;
   logic                   autoinit_i = 1'b1;
   logic                   pci_rst_i  = 1'b0;
   logic                   want       = 1'b0;
   logic [31:0]            wb_dat_o;
   logic [31:0]            q;
   logic                   wb_ack_o;
   logic                   host_req;
   logic                   host_grant;
   logic                   host_hold;
   pchd_pkg::pchd_live_t   live;
   int                     grants;
   int                     n_errors   = 0;
   int                     tests_run  = 0;
   logic [27:0]            rv [6]     = '{28'hffc0000, 28'hff80000, 28'h0ffffff,
                                          28'h0, 28'h0, 28'h0};

   always #50 clk_i = ~clk_i;

   pchd_regbank i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .autoinit_select_i(autoinit_i), .pci_rst_i(pci_rst_i), .host_req_i(host_req),
      .host_grant_o(host_grant), .host_hold_o(host_hold), .live_o(live));

   pchd_host_model i_host (
      .clk_i(clk_i), .want_i(want), .grant_i(host_grant), .req_o(host_req),
      .grants_o(grants));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task complete_run;
      $display("Checks %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Holds the request until ack is sampled, then releases it
   task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d);
      int n;
      @(posedge clk_i);
      wb <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: s, dat: d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) begin
         n_errors++;
         complete_run();
      end else begin
         q = wb_dat_o;
         wb <= '0;
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 4'hf, 32'h0);
      `CHK("read data", e, q)
   endtask

   task automatic boot(input logic ai);
      @(posedge clk_i);
      autoinit_i <= ai;
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_gated;
      boot(1'b1);
      want <= 1'b1;
      repeat (4) @(posedge clk_i);
      rd(8'h00, 32'h0);
      `CHK("hold", 1'b1, host_hold)
      `CHK("grants", 0, grants)
      for (int i = 0; i < 6; i++) begin
         rd(8'h04 + 8'(4 * i), {4'h0, rv[i]});
      end
      rd(8'h1c, 32'h1);
      rd(8'h20, 32'h0);
      $display("gated boot done");
   endtask

   task automatic t_write;
      for (int i = 0; i < 6; i++) begin
         bus(1'b1, 8'h04 + 8'(4 * i), 4'hf, 32'hffffffff);
         rd(8'h04 + 8'(4 * i), 32'h0fffffff);
      end
      bus(1'b1, 8'h10, 4'h1, 32'h12345678);
      rd(8'h10, 32'h0fffff78);
      bus(1'b1, 8'h1c, 4'hf, 32'hfffffffe);
      bus(1'b1, 8'h20, 4'hf, 32'hffffffff);
      rd(8'h1c, 32'h0);
      `CHK("live idle", rv[1], live.mask[1])
      @(posedge clk_i);
      pci_rst_i <= 1'b1;
      @(posedge clk_i);
      pci_rst_i <= 1'b0;
      @(posedge clk_i);
      `CHK("live w0", 28'hfffffff, live.mask[0])
      `CHK("live w3", 28'hfffff78, live.mask[3])
      `CHK("live w5", 28'hfffffff, live.mask[5])
      `CHK("live pf", 1'b0, live.prefetch0)
      $display("defaults and copy done");
   endtask

   task automatic t_release;
      bus(1'b1, 8'h00, 4'hf, 32'hffffffff);
      repeat (3) @(posedge clk_i);
      rd(8'h00, 32'h1);
      `CHK("hold", 1'b0, host_hold)
      `CHK("grant", 1'b1, host_grant)
      `CHK("grants open", 1'b1, grants > 0)
      bus(1'b1, 8'h00, 4'hf, 32'h0);
      repeat (3) @(posedge clk_i);
      `CHK("grant", 1'b0, host_grant)
      `CHK("hold", 1'b1, host_hold)
      $display("release done");
   endtask

   task automatic t_noauto;
      boot(1'b0);
      repeat (3) @(posedge clk_i);
      rd(8'h00, 32'h1);
      `CHK("hold", 1'b0, host_hold)
      `CHK("grant", 1'b1, host_grant)
      rd(8'h04, 32'h0ffc0000);
      $display("plain boot done");
   endtask

   initial begin
      t_gated();
      t_write();
      t_release();
      t_noauto();
      complete_run();
   end
endmodule
